// *** hdl/smrf_top.sv ***
// Contract
// - monitor on outside idle and sleep; qualified low supply resets all, sets voltage flag
// - low supply not lasting past qualify time is ignored, no reset
// - four threshold codes 55h 33h 99h aah select 2.1 2.55 3.15 3.8 V
// - any other code resets after software delay, sets threshold fault flag
// - bad-code reset restores threshold register to 55h
// - low-supply reset leaves threshold register unchanged
// - threshold register powers up at 55h, the lowest threshold
// - supply-monitor reset disabled during idle or sleep
// - flag bit 2 set on low-supply reset, cleared only by writing zero
// - flag bit 1 set on bad threshold code, cleared only by writing zero
// - bits 7 to 4 of flag and bandgap registers read zero
// - bandgap on when monitor active or bit 3 set; bit resets zero
// - run-mode watchdog time-out does full reset and sets time-out flag
// - sleep watchdog time-out clears only pc and sp, sets time-out flag
// - status flags: power-on clears, low supply keeps, wdt sets per mode
// - after power-on pc is zero and interrupts disabled
// - after power-on watchdog and time bases cleared, timers off
// - after power-on ports are inputs and sp points to stack top
`timescale 1ns/1ps
`default_nettype none

module smrf_top #(
    parameter logic [11:0] QUALIFY_CYCLES  = smrf_pkg::QUALIFY_CYCLES,
    parameter logic [11:0] SW_DELAY_CYCLES = smrf_pkg::SW_DELAY_CYCLES,
    parameter logic [11:0] HOLD_CYCLES     = smrf_pkg::HOLD_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clken,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        low_supply_in,
    input  wire logic        wdt_timeout,
    input  wire logic        sleep_idle,
    input  wire logic        status_clear,
    input  wire logic        rstc_fault_evt,
    input  wire logic        wdt_ctrl_fault_evt,
    output logic             device_reset,
    output logic             monitor_active,
    output logic      [1:0]  threshold_level,
    output logic             bandgap_output_enable,
    output logic             pc_clear,
    output logic             sp_to_top,
    output logic             int_disable,
    output logic             wdt_tb_clear,
    output logic             timer_off,
    output logic             port_input_mode
);

    // =====================================================================
    // signals
    smrf_pkg::smrf_state_t state;
    smrf_pkg::smrf_state_t next_state;
    logic [11:0]           cnt;
    logic [11:0]           next_cnt;

    logic [11:0]           qual_cnt;
    logic                  low_meta;
    logic                  low_sync;
    logic                  low_qual;
    logic                  active;

    logic [7:0]            threshold_code;
    logic                  code_valid;
    logic [1:0]            decoded_level;

    logic [3:0]            flags;
    logic [3:0]            flag_set;
    logic                  bandgap_bit;
    logic                  timeout_status_flag;
    logic                  powerdown_status_flag;

    logic                  enter_volt;
    logic                  enter_code;
    logic                  enter_wdt;
    logic                  wdt_sleep_evt;

    logic                  setup;
    logic                  wr;
    logic                  mapped;
    logic                  next_hold;

    // =====================================================================
    // apb slave handshake
    assign setup   = psel & ~penable & clken;
    assign wr      = psel & penable & pwrite & clken;
    assign pready  = clken;
    assign mapped  = (paddr == smrf_pkg::ADDR_THRESHOLD)
                   | (paddr == smrf_pkg::ADDR_FLAGS)
                   | (paddr == smrf_pkg::ADDR_BANDGAP)
                   | (paddr == smrf_pkg::ADDR_STATUS);
    assign pslverr = psel & penable & ~mapped;

    // =====================================================================
    // low supply synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_meta <= 1'b0;
            low_sync <= 1'b0;
        end else if (clken) begin
            low_meta <= low_supply_in;
            low_sync <= low_meta;
        end
    end

    // =====================================================================
    // qualification of low supply
    assign active = ~sleep_idle;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qual_cnt <= 12'h000;
        end else if (clken) begin
            if (!low_sync || !active || state == smrf_pkg::SMRF_ST_HOLD) begin
                qual_cnt <= 12'h000;
            end else if (qual_cnt != QUALIFY_CYCLES) begin
                qual_cnt <= qual_cnt + 12'h001;
            end
        end
    end

    // only a low level lasting past the qualify time counts
    assign low_qual = low_sync & active
                    & (qual_cnt == QUALIFY_CYCLES);

    // =====================================================================
    // threshold code decode
    always_comb begin
        code_valid    = 1'b1;
        decoded_level = smrf_pkg::LEVEL_2V10;
        case (threshold_code)
            smrf_pkg::CODE_2V10: decoded_level = smrf_pkg::LEVEL_2V10;
            smrf_pkg::CODE_2V55: decoded_level = smrf_pkg::LEVEL_2V55;
            smrf_pkg::CODE_3V15: decoded_level = smrf_pkg::LEVEL_3V15;
            smrf_pkg::CODE_3V80: decoded_level = smrf_pkg::LEVEL_3V80;
            default:             code_valid    = 1'b0;
        endcase
    end

    // =====================================================================
    // reset sequencer
    assign wdt_sleep_evt = clken & wdt_timeout & sleep_idle
                         & (state != smrf_pkg::SMRF_ST_HOLD);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        enter_volt = 1'b0;
        enter_code = 1'b0;
        enter_wdt  = 1'b0;
        case (state)
            smrf_pkg::SMRF_ST_HOLD: begin
                if (cnt >= HOLD_CYCLES - 12'h001) begin
                    next_state = smrf_pkg::SMRF_ST_RUN;
                    next_cnt   = 12'h000;
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end

            smrf_pkg::SMRF_ST_RUN: begin
                if (low_qual) begin
                    next_state = smrf_pkg::SMRF_ST_HOLD;
                    next_cnt   = 12'h000;
                    enter_volt = 1'b1;
                end else if (wdt_timeout && !sleep_idle) begin
                    next_state = smrf_pkg::SMRF_ST_HOLD;
                    next_cnt   = 12'h000;
                    enter_wdt  = 1'b1;
                end else if (!code_valid) begin
                    next_state = smrf_pkg::SMRF_ST_DELAY;
                    next_cnt   = 12'h000;
                end
            end

            smrf_pkg::SMRF_ST_DELAY: begin
                if (low_qual) begin
                    next_state = smrf_pkg::SMRF_ST_HOLD;
                    next_cnt   = 12'h000;
                    enter_volt = 1'b1;
                end else if (wdt_timeout && !sleep_idle) begin
                    next_state = smrf_pkg::SMRF_ST_HOLD;
                    next_cnt   = 12'h000;
                    enter_wdt  = 1'b1;
                end else if (cnt >= SW_DELAY_CYCLES - 12'h001) begin
                    next_state = smrf_pkg::SMRF_ST_HOLD;
                    next_cnt   = 12'h000;
                    enter_code = 1'b1;
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end

            default: begin
                next_state = smrf_pkg::SMRF_ST_HOLD;
                next_cnt   = 12'h000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= smrf_pkg::SMRF_ST_HOLD;
            cnt   <= 12'h000;
        end else if (clken) begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign next_hold = (next_state == smrf_pkg::SMRF_ST_HOLD);

    // =====================================================================
    // threshold select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_code <= smrf_pkg::THRESHOLD_RESET;
        end else if (clken) begin
            if (enter_code) begin
                threshold_code <= smrf_pkg::THRESHOLD_RESET;
            end else if (wr && paddr == smrf_pkg::ADDR_THRESHOLD) begin
                // a low-supply reset never touches this register
                threshold_code <= pwdata[7:0];
            end
        end
    end

    // =====================================================================
    // reset cause flags
    always_comb begin
        flag_set = 4'h0;
        flag_set[smrf_pkg::FLAG_VOLTAGE_BIT]   = enter_volt;
        flag_set[smrf_pkg::FLAG_THRESHOLD_BIT] = enter_code;
        flag_set[smrf_pkg::FLAG_RESET_REG_BIT] = rstc_fault_evt;
        flag_set[smrf_pkg::FLAG_WDT_REG_BIT]   = wdt_ctrl_fault_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= smrf_pkg::FLAGS_RESET;
        end else if (clken) begin
            if (wr && paddr == smrf_pkg::ADDR_FLAGS) begin
                flags <= (flags & pwdata[3:0]) | flag_set;
            end else begin
                flags <= flags | flag_set;
            end
        end
    end

    // =====================================================================
    // bandgap control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bandgap_bit <= smrf_pkg::BANDGAP_RESET;
        end else if (clken) begin
            if (wr && paddr == smrf_pkg::ADDR_BANDGAP) begin
                bandgap_bit <= pwdata[smrf_pkg::BANDGAP_EN_BIT];
            end
        end
    end

    // =====================================================================
    // timeout and powerdown status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_status_flag   <= 1'b0;
            powerdown_status_flag <= 1'b0;
        end else if (clken) begin
            // low-supply reset leaves both flags alone
            timeout_status_flag <= (timeout_status_flag & ~status_clear)
                                 | enter_wdt | wdt_sleep_evt;
            powerdown_status_flag <= (powerdown_status_flag & ~status_clear)
                                   | wdt_sleep_evt;
        end
    end

    // =====================================================================
    // reset effect outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset    <= 1'b1;
            pc_clear        <= 1'b1;
            int_disable     <= 1'b1;
            wdt_tb_clear    <= 1'b1;
            timer_off       <= 1'b1;
            port_input_mode <= 1'b1;
            sp_to_top       <= 1'b1;
        end else if (clken) begin
            device_reset    <= next_hold;
            pc_clear        <= next_hold | wdt_sleep_evt;
            sp_to_top       <= next_hold | wdt_sleep_evt;
            int_disable     <= next_hold;
            wdt_tb_clear    <= next_hold;
            timer_off       <= next_hold;
            port_input_mode <= next_hold;
        end
    end

    // =====================================================================
    // monitor and bandgap outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_active        <= 1'b1;
            bandgap_output_enable <= 1'b1;
            threshold_level       <= smrf_pkg::LEVEL_2V10;
        end else if (clken) begin
            monitor_active        <= active;
            bandgap_output_enable <= active | bandgap_bit;
            threshold_level       <= decoded_level;
        end
    end

    // =====================================================================
    // read data, latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                smrf_pkg::ADDR_THRESHOLD: prdata[7:0] <= threshold_code;
                smrf_pkg::ADDR_FLAGS:     prdata[3:0] <= flags;
                smrf_pkg::ADDR_BANDGAP:
                    prdata[smrf_pkg::BANDGAP_EN_BIT] <= bandgap_bit;
                smrf_pkg::ADDR_STATUS: begin
                    prdata[smrf_pkg::STATUS_TIMEOUT_BIT] <= timeout_status_flag;
                    prdata[smrf_pkg::STATUS_PDOWN_BIT]   <= powerdown_status_flag;
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** hdl/smrf_pkg.sv ***
package smrf_pkg;

    // =====================================================================
    // clock
    localparam int unsigned CLK_PERIOD_NS = 10;

    // =====================================================================
    // register byte offsets
    localparam logic [11:0] ADDR_THRESHOLD = 12'h000;
    localparam logic [11:0] ADDR_FLAGS     = 12'h004;
    localparam logic [11:0] ADDR_BANDGAP   = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00c;

    // =====================================================================
    // threshold codes and reset values
    localparam logic [7:0] THRESHOLD_RESET = 8'h55;
    localparam logic [7:0] CODE_2V10       = 8'h55;
    localparam logic [7:0] CODE_2V55       = 8'h33;
    localparam logic [7:0] CODE_3V15       = 8'h99;
    localparam logic [7:0] CODE_3V80       = 8'haa;
    localparam logic [1:0] LEVEL_2V10      = 2'h0;
    localparam logic [1:0] LEVEL_2V55      = 2'h1;
    localparam logic [1:0] LEVEL_3V15      = 2'h2;
    localparam logic [1:0] LEVEL_3V80      = 2'h3;
    localparam logic [3:0] FLAGS_RESET     = 4'h0;
    localparam logic       BANDGAP_RESET   = 1'b0;

    // =====================================================================
    // field positions
    localparam int unsigned FLAG_WDT_REG_BIT   = 0;
    localparam int unsigned FLAG_THRESHOLD_BIT = 1;
    localparam int unsigned FLAG_VOLTAGE_BIT   = 2;
    localparam int unsigned FLAG_RESET_REG_BIT = 3;
    localparam int unsigned BANDGAP_EN_BIT     = 3;
    localparam int unsigned STATUS_TIMEOUT_BIT = 0;
    localparam int unsigned STATUS_PDOWN_BIT   = 1;

    // =====================================================================
    // timing
    localparam int unsigned LOW_SUPPLY_QUALIFY_TIME_NS = 20000;
    localparam int unsigned SOFTWARE_RESET_DELAY_NS    = 10000;
    localparam int unsigned RESET_HOLD_TIME_NS         = 1000;
    localparam logic [11:0] QUALIFY_CYCLES =
        12'((LOW_SUPPLY_QUALIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SW_DELAY_CYCLES =
        12'((SOFTWARE_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] HOLD_CYCLES =
        12'((RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // =====================================================================
    // sequencer states, gray along hold -> run -> delay
    typedef enum logic [1:0] {
        SMRF_ST_HOLD  = 2'b00,
        SMRF_ST_RUN   = 2'b01,
        SMRF_ST_DELAY = 2'b11
    } smrf_state_t;

endpackage

// *** verification/smrf_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module smrf_checker #(
    parameter logic [11:0] QUALIFY_CYCLES = 12'h004,
    parameter logic [11:0] HOLD_CYCLES    = 12'h003
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        low_supply_in,
    input wire logic        wdt_timeout,
    input wire logic        sleep_idle,
    input wire logic        device_reset,
    input wire logic        monitor_active,
    input wire logic        bandgap_output_enable,
    input wire logic        pc_clear,
    input wire logic        sp_to_top,
    input wire logic        int_disable,
    input wire logic        timer_off
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [11:0] hold_cnt;
    logic [11:0] low_cnt;
    wire  logic  mapped = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
    // ==========
    // helper counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 12'h000;
            low_cnt  <= 12'h000;
        end else begin
            hold_cnt <= device_reset ? hold_cnt + 12'h001 : 12'h000;
            low_cnt  <= (low_supply_in && !sleep_idle && !device_reset) ?
                        low_cnt + 12'h001 : 12'h000;
        end
    end
    // ==========
    // properties
    property p_hold;
        $fell(device_reset) |-> hold_cnt == HOLD_CYCLES;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset hold length wrong");
    property p_supply;
        low_cnt == QUALIFY_CYCLES + 12'h001 |-> ##[1:6] device_reset;
    endproperty
    a_supply: assert property (p_supply)
        else $error("no supply reset");
    property p_slverr;
        psel && penable |-> pslverr == !mapped;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("slave error wrong");
    property p_rsvd;
        psel && penable && (paddr == 12'h004 || paddr == 12'h008)
            |-> prdata[31:4] == 28'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("unused bits set");
    property p_mon;
        $past(presetn) |-> monitor_active == !$past(sleep_idle);
    endproperty
    a_mon: assert property (p_mon)
        else $error("monitor active wrong");
    property p_bg;
        monitor_active && $past(monitor_active) |-> bandgap_output_enable;
    endproperty
    a_bg: assert property (p_bg)
        else $error("bandgap off");
    property p_wdt_run;
        wdt_timeout && !sleep_idle && !device_reset |-> ##[1:2] device_reset;
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("no watchdog reset");
    property p_wdt_sleep;
        wdt_timeout && sleep_idle && !device_reset
            |-> ##1 (pc_clear && sp_to_top && !device_reset);
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep)
        else $error("sleep time-out wrong");
    property p_effects;
        device_reset |-> pc_clear && sp_to_top && int_disable && timer_off;
    endproperty
    a_effects: assert property (p_effects)
        else $error("reset effect missing");
    c_rst: cover property ($rose(device_reset));
    c_sleep_wdt: cover property (pc_clear && !device_reset);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind smrf_top smrf_checker #(
    .QUALIFY_CYCLES(QUALIFY_CYCLES),
    .HOLD_CYCLES   (HOLD_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .low_supply_in(low_supply_in), .wdt_timeout(wdt_timeout),
    .sleep_idle(sleep_idle), .device_reset(device_reset),
    .monitor_active(monitor_active),
    .bandgap_output_enable(bandgap_output_enable),
    .pc_clear(pc_clear), .sp_to_top(sp_to_top),
    .int_disable(int_disable), .timer_off(timer_off)
);
`default_nettype wire

// *** verification/smrf_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// far side stand-in
module smrf_far_side (
    input  wire logic pclk,
    output logic      low_supply_in,
    output logic      wdt_timeout,
    output logic      sleep_idle,
    output logic      status_clear,
    output logic      rstc_fault_evt,
    output logic      wdt_ctrl_fault_evt
);
    logic [3:0] ev = 4'h0;
    assign {wdt_ctrl_fault_evt, rstc_fault_evt, status_clear, wdt_timeout}
        = ev;
    initial begin
        low_supply_in = 1'b0;
        sleep_idle    = 1'b0;
    end
    // supply dip
    task automatic dip(input int len);
        @(posedge pclk);
        low_supply_in <= 1'b1;
        repeat (len) @(posedge pclk);
        low_supply_in <= 1'b0;
    endtask
    // pulse: 0 time-out, 1 clear, 2/3 faults
    task automatic pulse(input int w);
        @(posedge pclk);
        ev[w] <= 1'b1;
        @(posedge pclk);
        ev <= 4'h0;
    endtask
    task automatic set_sleep(input logic v);
        @(posedge pclk);
        sleep_idle <= v;
    endtask
endmodule
`default_nettype wire

// *** verification/tb_supply_monitor_reset_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_supply_monitor_reset_flags;
    localparam logic [11:0] SWD = 12'h006;
    localparam logic [11:0] A_T = smrf_pkg::ADDR_THRESHOLD;
    localparam logic [11:0] A_F = smrf_pkg::ADDR_FLAGS;
    localparam logic [11:0] A_B = smrf_pkg::ADDR_BANDGAP;
    localparam logic [11:0] A_S = smrf_pkg::ADDR_STATUS;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, rd;
    logic [1:0]  threshold_level;
    logic        device_reset, monitor_active, bandgap_output_enable;
    logic        pc_clear, sp_to_top, int_disable, wdt_tb_clear, timer_off;
    logic        port_input_mode, seen, clken = 1'b1;
    wire  logic  low_supply_in, wdt_timeout, sleep_idle, status_clear;
    wire  logic  rstc_fault_evt, wdt_ctrl_fault_evt;
    int          miscompares, samples_checked, thr_m, flags_m, stat_m, bg_m, n;
    int          codes[4] = '{'h55, 'h33, 'h99, 'haa};
    smrf_top #(.QUALIFY_CYCLES(12'h004), .SW_DELAY_CYCLES(SWD),
        .HOLD_CYCLES(12'h003)) dut_u (
        .pclk(pclk), .presetn(presetn), .clken(clken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_supply_in(low_supply_in), .wdt_timeout(wdt_timeout),
        .sleep_idle(sleep_idle), .status_clear(status_clear),
        .rstc_fault_evt(rstc_fault_evt),
        .wdt_ctrl_fault_evt(wdt_ctrl_fault_evt),
        .device_reset(device_reset), .monitor_active(monitor_active),
        .threshold_level(threshold_level),
        .bandgap_output_enable(bandgap_output_enable), .pc_clear(pc_clear),
        .sp_to_top(sp_to_top), .int_disable(int_disable),
        .wdt_tb_clear(wdt_tb_clear), .timer_off(timer_off),
        .port_input_mode(port_input_mode));
    smrf_far_side u_far (
        .pclk(pclk), .low_supply_in(low_supply_in), .wdt_timeout(wdt_timeout),
        .sleep_idle(sleep_idle), .status_clear(status_clear),
        .rstc_fault_evt(rstc_fault_evt),
        .wdt_ctrl_fault_evt(wdt_ctrl_fault_evt));
    // ==========
    // reporting
    task automatic tally_and_finish;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_reg(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_pin(string nm, logic exp, logic got);
        chk_reg(nm, {31'h0, exp}, {31'h0, got});
    endtask
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ==========
    // bus and waits
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(string nm, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_reg(nm, exp, rd);
    endtask
    task automatic regs_chk;
        rdchk("threshold", A_T, thr_m);
        rdchk("flags", A_F, flags_m);
        rdchk("bandgap", A_B, bg_m);
        rdchk("status", A_S, stat_m);
    endtask
    task automatic wait_lvl(logic v, int bound);
        n = 0;
        while (device_reset !== v && n < bound) begin
            @(posedge pclk);
            n++;
        end
        if (n == bound) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic quiet(string nm);
        seen = 1'b0;
        repeat (12) @(posedge pclk) seen = seen | device_reset;
        chk_pin(nm, 1'b0, seen);
    endtask
    task automatic por;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk_pin("int_disable", 1'b1, int_disable);
        chk_pin("timer_off", 1'b1, timer_off);
        chk_pin("wdt_tb_clear", 1'b1, wdt_tb_clear);
        chk_pin("port_input_mode", 1'b1, port_input_mode);
        presetn <= 1'b1;
        thr_m = 'h55;
        flags_m = 0;
        stat_m = 0;
        bg_m = 0;
        wait_lvl(1'b0, 40);
        regs_chk();
        $display("power-on test done");
    endtask
    // ==========
    // stimulus
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rnd = 32'h5148e319;
        miscompares = 0;
        samples_checked = 0;
        por();
        apb(1'b1, {rnd[11:4] | 8'h01, 4'h0}, rnd);
        chk_pin("pslverr", 1'b1, err);
        rdchk("unmapped", {rnd[11:4] | 8'h01, 4'h0}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, A_T, codes[k]);
            thr_m = codes[k];
            rdchk("threshold", A_T, thr_m);
            chk_reg("level", k, {30'h0, threshold_level});
        end
        rnd = lfsr(rnd);
        apb(1'b1, A_B, rnd);
        bg_m = rnd & 32'h8;
        rdchk("bandgap", A_B, bg_m);
        u_far.set_sleep(1'b1);
        repeat (3) @(posedge pclk);
        chk_pin("bandgap_en", bg_m[3], bandgap_output_enable);
        u_far.dip(20);
        quiet("sleep_reset");
        u_far.set_sleep(1'b0);
        u_far.dip(1 + rnd[1:0]);
        quiet("glitch_reset");
        $display("glitch test done");
        fork
            u_far.dip(8);
        join_none
        wait_lvl(1'b1, 30);
        flags_m |= 4;
        wait_lvl(1'b0, 40);
        regs_chk();
        rnd = lfsr(rnd);
        apb(1'b1, A_F, rnd | 32'hf);
        rdchk("flags_ones", A_F, flags_m);
        u_far.pulse(2);
        u_far.pulse(3);
        flags_m |= 9;
        apb(1'b1, A_F, 32'h7);
        flags_m &= 7;
        rdchk("flags_partial", A_F, flags_m);
        apb(1'b1, A_F, 32'h0);
        flags_m = 0;
        rdchk("flags_clear", A_F, flags_m);
        $display("flag test done");
        rnd = lfsr(rnd);
        for (int k = 0; k < 4; k++)
            if (rnd[7:0] == codes[k]) rnd[0] = ~rnd[0];
        apb(1'b1, A_T, {24'h0, rnd[7:0]});
        wait_lvl(1'b1, 40);
        chk_pin("bad_delay", 1'b1, n >= SWD && n <= SWD + 4);
        thr_m = 'h55;
        flags_m |= 2;
        wait_lvl(1'b0, 40);
        regs_chk();
        u_far.pulse(0);
        wait_lvl(1'b1, 5);
        stat_m |= 1;
        wait_lvl(1'b0, 40);
        regs_chk();
        u_far.pulse(1);
        stat_m = 0;
        rdchk("status_clear", A_S, stat_m);
        u_far.set_sleep(1'b1);
        u_far.pulse(0);
        #1;
        chk_pin("pc_clear", 1'b1, pc_clear);
        chk_pin("sleep_wdt_reset", 1'b0, device_reset);
        stat_m |= 3;
        u_far.set_sleep(1'b0);
        regs_chk();
        clken <= 1'b0;
        u_far.pulse(1);
        clken <= 1'b1;
        regs_chk();
        $display("watchdog test done");
        apb(1'b1, A_T, 32'haa);
        por();
        tally_and_finish();
    end
endmodule
`default_nettype wire
